/* hdl/dmct_pkg.sv */
// Constants, register map and carrier types of the dual-mode compare timer.
// Assumes an 8-bit CPU register port with 16-bit addresses and one system clock.
// Function
// - High select top 0 cascades halves into one 16-bit up-counter.
// - 16-bit mode counts on the low-half clock select source.
// - High select top 1 runs two independent 8-bit counters.
// - 16-bit mode clears whole counter on match when high clear bit set.
// - 8-bit mode clears each half on its own match if enabled.
// - 16-bit wrap sets high overflow flag; request if overflow enable.
// - 8-bit half wrap sets its overflow flag; request only if enabled.
// - Reset clears both counter halves.
// - Reset sets both compare halves to all ones.
// - 16-bit match sets high match flag and high request together.
// - 8-bit half match sets its match flag and request together.
// - 16-bit mode toggles high pin on each wide match.
// - 8-bit mode toggles each pin on its own half match.
// - Writing high toggle level drives high pin at once; reset low.
// - Writing low toggle level drives low pin right after write.
// - High select codes 100..111 pick four internal clocks.
// - Low select top 0 picks event edges; 100..111 internal clocks.
// - Event input feeds only the low half.
// - CPU reads and writes halves; 16-bit mode goes through temp register.
// - Mode clock control is write-only, eight bits, reset zero.
// - Counting on the watch clock continues in low-power modes.
// - Clock stop register bit places the timer in module standby.
// - Flags set by hardware; cleared by writing 0 after reading 1.
package dmct_pkg;
  localparam logic [15:0] ADDR_MODE_CTRL  = 16'hffb6;
  localparam logic [15:0] ADDR_FLAG_CTRL  = 16'hffb7;
  localparam logic [15:0] ADDR_CNT_HIGH   = 16'hffb8;
  localparam logic [15:0] ADDR_CNT_LOW    = 16'hffb9;
  localparam logic [15:0] ADDR_CMP_HIGH   = 16'hffba;
  localparam logic [15:0] ADDR_CMP_LOW    = 16'hffbb;
  localparam logic [15:0] ADDR_CLK_STOP   = 16'hfffa;
  localparam logic [7:0]  RST_MODE_CTRL   = 8'h00;
  localparam logic [7:0]  RST_FLAG_CTRL   = 8'h00;
  localparam logic [7:0]  RST_CNT         = 8'h00;
  localparam logic [7:0]  RST_CMP         = 8'hff;
  localparam logic [7:0]  RST_CLK_STOP    = 8'hff;
  localparam logic [7:0]  HALF_ONES       = 8'hff;
  localparam int          BIT_TOL_HIGH    = 7;
  localparam int          BIT_TOL_LOW     = 3;
  localparam int          BIT_STOP        = 2;
  localparam int          BIT_OVF_H       = 7;
  localparam int          BIT_CMF_H       = 6;
  localparam int          BIT_OVIE_H      = 5;
  localparam int          BIT_CCLR_H      = 4;
  localparam int          BIT_OVF_L       = 3;
  localparam int          BIT_CMF_L       = 2;
  localparam int          BIT_OVIE_L      = 1;
  localparam int          BIT_CCLR_L      = 0;
  localparam logic [7:0]  FLAG_MASK       = 8'hcc;

  typedef struct packed {
    logic        high_toggle_level;
    logic [2:0]  high_sel;
    logic        low_toggle_level;
    logic [2:0]  low_sel;
  } dmct_mode_type;

  typedef struct packed {
    logic        div32;
    logic        div16;
    logic        div4;
    logic        watch4;
  } dmct_ticks_type;
endpackage : dmct_pkg

/* hdl/dmct_timer.sv */
// Dual-mode compare timer: counter, compare, flags, toggle pins, CPU port.
// Assumes one-cycle prescaler tick inputs on clk and a synchronous CPU port
// whose read data is registered one cycle after the read strobe.
`timescale 1ns/10ps
module dmct_timer (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic [15:0]              addr,
  input  wire logic                     wr_en,
  input  wire logic                     rd_en,
  input  wire logic [7:0]               wr_data,
  input  wire dmct_pkg::dmct_ticks_type ticks,
  input  wire logic                     event_input_pin,
  input  wire logic                     event_rising,
  output logic [7:0]                    rd_data,
  output logic                          high_toggle_pin,
  output logic                          low_toggle_pin,
  output logic                          high_irq_request,
  output logic                          low_irq_request
);
  dmct_pkg::dmct_mode_type mode;
  logic [7:0]  flags;
  logic [7:0]  counter_high_half;
  logic [7:0]  counter_low_half;
  logic [7:0]  compare_high_half;
  logic [7:0]  compare_low_half;
  logic [7:0]  module_clock_stop;
  logic [7:0]  temp;
  logic [1:0]  seen_one;
  logic [1:0]  seen_ovf;
  logic        ev_s1;
  logic        ev_s2;
  logic        ev_s3;

  function automatic logic pick_tick(input logic [2:0] sel,
                                     input dmct_pkg::dmct_ticks_type t);
    case (sel)
      3'h4:    pick_tick = t.div32;
      3'h5:    pick_tick = t.div16;
      3'h6:    pick_tick = t.div4;
      3'h7:    pick_tick = t.watch4;
      default: pick_tick = 1'b0;
    endcase
  endfunction : pick_tick

  // Event pin synchroniser; only the second and third stages feed logic.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ev_s1 <= 1'b0;
      ev_s2 <= 1'b0;
      ev_s3 <= 1'b0;
    end else begin
      ev_s1 <= event_input_pin;
      ev_s2 <= ev_s1;
      ev_s3 <= ev_s2;
    end
  end

  wire wide_mode = ~mode.high_sel[2];
  wire running   = module_clock_stop[dmct_pkg::BIT_STOP];
  wire ev_edge   = event_rising ? (ev_s2 & ~ev_s3) : (~ev_s2 & ev_s3);
  // The watch tick is an ordinary input, so low-power modes keep it going.
  wire low_tick  = running & (mode.low_sel[2] ? pick_tick(mode.low_sel, ticks)
                                              : ev_edge);
  wire high_src  = running & pick_tick(mode.high_sel, ticks);

  wire match_low  = counter_low_half == compare_low_half;
  wire match_high = counter_high_half == compare_high_half;
  wire match_wide = match_low & match_high;
  wire low_wrap   = low_tick & (counter_low_half == dmct_pkg::HALF_ONES);
  wire high_tick  = wide_mode ? low_wrap : high_src;
  wire high_wrap  = high_tick & (counter_high_half == dmct_pkg::HALF_ONES);

  // Match events fire when the counter first reaches the compare value.
  logic match_low_q;
  logic match_high_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      match_low_q  <= 1'b0;
      match_high_q <= 1'b0;
    end else begin
      match_low_q  <= wide_mode ? 1'b0 : match_low;
      match_high_q <= wide_mode ? match_wide : match_high;
    end
  end
  wire ev_match_l = ~wide_mode & match_low & ~match_low_q;
  wire ev_match_h = (wide_mode ? match_wide : match_high) & ~match_high_q;
  wire ev_ovf_h   = high_wrap;
  wire ev_ovf_l   = ~wide_mode & low_wrap;

  wire clr_h = flags[dmct_pkg::BIT_CCLR_H] & ev_match_h;
  wire clr_l = wide_mode ? clr_h
                         : (flags[dmct_pkg::BIT_CCLR_L] & ev_match_l);

  wire sel_mode  = addr == dmct_pkg::ADDR_MODE_CTRL;
  wire sel_flag  = addr == dmct_pkg::ADDR_FLAG_CTRL;
  wire sel_cnt_h = addr == dmct_pkg::ADDR_CNT_HIGH;
  wire sel_cnt_l = addr == dmct_pkg::ADDR_CNT_LOW;
  wire sel_cmp_h = addr == dmct_pkg::ADDR_CMP_HIGH;
  wire sel_cmp_l = addr == dmct_pkg::ADDR_CMP_LOW;
  wire sel_stop  = addr == dmct_pkg::ADDR_CLK_STOP;

  // In 16-bit mode an upper-byte write only loads temp; the lower write commits.
  wire wr_cnt_h = wr_en & sel_cnt_h & ~wide_mode;
  wire wr_cnt_l = wr_en & sel_cnt_l;
  wire wr_cmp_h = wr_en & sel_cmp_h & ~wide_mode;
  wire wr_cmp_l = wr_en & sel_cmp_l;
  wire wr_tmp   = wr_en & wide_mode & (sel_cnt_h | sel_cmp_h);
  wire rd_tmp   = rd_en & wide_mode & (sel_cnt_h | sel_cmp_h);

  wire [7:0] next_cnt_h = wr_en & wide_mode & sel_cnt_l ? temp
                        : wr_cnt_h ? wr_data
                        : clr_h ? 8'h00
                        : high_tick ? 8'(counter_high_half + 8'h01)
                        : counter_high_half;
  wire [7:0] next_cnt_l = wr_cnt_l ? wr_data
                        : clr_l ? 8'h00
                        : low_tick ? 8'(counter_low_half + 8'h01)
                        : counter_low_half;

  // Flag clear needs a prior read of 1; a set in the same cycle wins.
  wire [7:0] flag_set = {ev_ovf_h, ev_match_h, 2'b00, ev_ovf_l, ev_match_l, 2'b00};
  wire [7:0] seen_bits = {seen_ovf[1], seen_one[1], 2'b00, seen_ovf[0], seen_one[0], 2'b00};
  wire [7:0] flag_clr = (wr_en & sel_flag) ? (~wr_data & seen_bits) : 8'h00;
  wire [7:0] next_flags = (wr_en & sel_flag)
                        ? (((flags & dmct_pkg::FLAG_MASK) & ~flag_clr)
                           | (wr_data & ~dmct_pkg::FLAG_MASK) | flag_set)
                        : (flags | flag_set);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode              <= dmct_pkg::RST_MODE_CTRL;
      flags             <= dmct_pkg::RST_FLAG_CTRL;
      counter_high_half <= dmct_pkg::RST_CNT;
      counter_low_half  <= dmct_pkg::RST_CNT;
      compare_high_half <= dmct_pkg::RST_CMP;
      compare_low_half  <= dmct_pkg::RST_CMP;
      module_clock_stop <= dmct_pkg::RST_CLK_STOP;
      temp              <= 8'h00;
    end else begin
      if (wr_en & sel_mode) begin
        mode <= wr_data;
      end
      flags             <= next_flags;
      counter_high_half <= next_cnt_h;
      counter_low_half  <= next_cnt_l;
      if (wr_en & wide_mode & sel_cmp_l) begin
        compare_high_half <= temp;
      end else if (wr_cmp_h) begin
        compare_high_half <= wr_data;
      end
      if (wr_cmp_l) begin
        compare_low_half <= wr_data;
      end
      if (wr_en & sel_stop) begin
        module_clock_stop <= wr_data;
      end
      if (wr_tmp) begin
        temp <= wr_data;
      end else if (rd_tmp) begin
        temp <= sel_cnt_h ? counter_low_half : compare_low_half;
      end
    end
  end

  // Remembers which flags software has seen set, for the clear condition.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seen_one <= 2'b00;
      seen_ovf <= 2'b00;
    end else if (rd_en & sel_flag) begin
      seen_one <= {flags[dmct_pkg::BIT_CMF_H], flags[dmct_pkg::BIT_CMF_L]};
      seen_ovf <= {flags[dmct_pkg::BIT_OVF_H], flags[dmct_pkg::BIT_OVF_L]};
    end else if (wr_en & sel_flag) begin
      seen_one <= 2'b00;
      seen_ovf <= 2'b00;
    end
  end

  wire [7:0] rd_mux = sel_flag ? flags
                    : sel_cnt_h ? counter_high_half
                    : sel_cnt_l ? (wide_mode ? temp : counter_low_half)
                    : sel_cmp_h ? compare_high_half
                    : sel_cmp_l ? (wide_mode ? temp : compare_low_half)
                    : sel_stop ? module_clock_stop
                    : 8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      rd_data <= rd_mux;
    end
  end

  wire req_h = ev_match_h | (ev_ovf_h & flags[dmct_pkg::BIT_OVIE_H]);
  wire req_l = ev_match_l | (ev_ovf_l & flags[dmct_pkg::BIT_OVIE_L]);
  wire tog_h = ev_match_h;
  wire tog_l = ev_match_l;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      high_toggle_pin  <= 1'b0;
      low_toggle_pin   <= 1'b0;
      high_irq_request <= 1'b0;
      low_irq_request  <= 1'b0;
    end else begin
      if (wr_en & sel_mode) begin
        high_toggle_pin <= wr_data[dmct_pkg::BIT_TOL_HIGH];
        low_toggle_pin  <= wr_data[dmct_pkg::BIT_TOL_LOW];
      end else begin
        high_toggle_pin <= high_toggle_pin ^ tog_h;
        low_toggle_pin  <= low_toggle_pin ^ tog_l;
      end
      high_irq_request <= req_h;
      low_irq_request  <= req_l;
    end
  end

  wide_ovf_a: assert property (@(posedge clk) disable iff (rst)
    ev_ovf_h |=> flags[dmct_pkg::BIT_OVF_H]) else $error("high overflow flag not set");
  low_ovf_a: assert property (@(posedge clk) disable iff (rst)
    ev_ovf_l |=> flags[dmct_pkg::BIT_OVF_L]) else $error("low overflow flag not set");
  ovf_req_a: assert property (@(posedge clk) disable iff (rst)
    (ev_ovf_l & ~ev_match_l & ~flags[dmct_pkg::BIT_OVIE_L]) |=> ~low_irq_request)
    else $error("low request without enable");
  match_flag_a: assert property (@(posedge clk) disable iff (rst)
    ev_match_h |=> (flags[dmct_pkg::BIT_CMF_H] & high_irq_request))
    else $error("high match flag and request not together");
  low_match_a: assert property (@(posedge clk) disable iff (rst)
    ev_match_l |=> (flags[dmct_pkg::BIT_CMF_L] & low_irq_request))
    else $error("low match flag and request not together");
  wide_clear_a: assert property (@(posedge clk) disable iff (rst)
    (wide_mode & ev_match_h & flags[dmct_pkg::BIT_CCLR_H] & ~wr_en)
    |=> (counter_high_half == 8'h00 && counter_low_half == 8'h00))
    else $error("wide counter not cleared");
  toggle_high_a: assert property (@(posedge clk) disable iff (rst)
    (ev_match_h & ~(wr_en & sel_mode)) |=> (high_toggle_pin != $past(high_toggle_pin)))
    else $error("high pin did not toggle");
  level_low_a: assert property (@(posedge clk) disable iff (rst)
    (wr_en & sel_mode) |=> (low_toggle_pin == $past(wr_data[dmct_pkg::BIT_TOL_LOW])))
    else $error("low pin not at written level");
  standby_hold_a: assert property (@(posedge clk) disable iff (rst)
    (~running & ~wr_en) |=> $stable(counter_low_half))
    else $error("counter moved in standby");
  flag_sw_set_a: assert property (@(posedge clk) disable iff (rst)
    (~flags[dmct_pkg::BIT_OVF_L] & ~ev_ovf_l) |=> ~flags[dmct_pkg::BIT_OVF_L])
    else $error("overflow flag set without event");

  // The upper byte steps only on a low-byte wrap while the halves are cascaded.
  wide_carry_a: assert property (@(posedge clk) disable iff (rst)
    (wide_mode & low_wrap & ~wr_en & ~clr_h)
    |=> (counter_high_half == 8'($past(counter_high_half) + 8'h01)))
    else $error("upper byte missed the carry");
  wide_hold_a: assert property (@(posedge clk) disable iff (rst)
    (wide_mode & ~low_wrap & ~wr_en & ~clr_h) |=> $stable(counter_high_half))
    else $error("upper byte moved without carry");

  // The low byte follows its own selected source in both modes.
  low_step_a: assert property (@(posedge clk) disable iff (rst)
    (low_tick & ~wr_en & ~clr_l)
    |=> (counter_low_half == 8'($past(counter_low_half) + 8'h01)))
    else $error("low byte missed its tick");
  split_step_a: assert property (@(posedge clk) disable iff (rst)
    (~wide_mode & high_src & ~wr_en & ~clr_h)
    |=> (counter_high_half == 8'($past(counter_high_half) + 8'h01)))
    else $error("high half missed its tick");

  // Without its own tick the split high half never sees the event pin.
  high_no_event_a: assert property (@(posedge clk) disable iff (rst)
    (~wide_mode & ~high_src & ~wr_en & ~clr_h) |=> $stable(counter_high_half))
    else $error("high half moved without its tick");

  // Each split half clears on its own match when its clear bit is set.
  split_clr_low_a: assert property (@(posedge clk) disable iff (rst)
    (~wide_mode & clr_l & ~wr_en) |=> (counter_low_half == 8'h00))
    else $error("low half not cleared on match");
  split_clr_high_a: assert property (@(posedge clk) disable iff (rst)
    (~wide_mode & clr_h & ~wr_en) |=> (counter_high_half == 8'h00))
    else $error("high half not cleared on match");

  // Enabled overflows raise a request in the next cycle.
  high_ovf_req_a: assert property (@(posedge clk) disable iff (rst)
    (ev_ovf_h & flags[dmct_pkg::BIT_OVIE_H]) |=> high_irq_request)
    else $error("high overflow request missing");
  low_ovf_req_a: assert property (@(posedge clk) disable iff (rst)
    (ev_ovf_l & flags[dmct_pkg::BIT_OVIE_L]) |=> low_irq_request)
    else $error("low overflow request missing");

  // The low pin toggles on low matches in split mode only.
  toggle_low_a: assert property (@(posedge clk) disable iff (rst)
    (ev_match_l & ~(wr_en & sel_mode)) |=> (low_toggle_pin != $past(low_toggle_pin)))
    else $error("low pin did not toggle");
  wide_low_quiet_a: assert property (@(posedge clk) disable iff (rst)
    (wide_mode & ~(wr_en & sel_mode)) |=> $stable(low_toggle_pin))
    else $error("low pin moved in 16-bit mode");
  level_high_a: assert property (@(posedge clk) disable iff (rst)
    (wr_en & sel_mode) |=> (high_toggle_pin == $past(wr_data[dmct_pkg::BIT_TOL_HIGH])))
    else $error("high pin not at written level");

  // Match flags are only ever set by a match event.
  low_cmf_set_a: assert property (@(posedge clk) disable iff (rst)
    (~flags[dmct_pkg::BIT_CMF_L] & ~ev_match_l) |=> ~flags[dmct_pkg::BIT_CMF_L])
    else $error("low match flag set without event");
  high_cmf_set_a: assert property (@(posedge clk) disable iff (rst)
    (~flags[dmct_pkg::BIT_CMF_H] & ~ev_match_h) |=> ~flags[dmct_pkg::BIT_CMF_H])
    else $error("high match flag set without event");

  // Standby freezes the upper byte as well.
  standby_high_a: assert property (@(posedge clk) disable iff (rst)
    (~running & ~wr_en & ~clr_h) |=> $stable(counter_high_half))
    else $error("upper byte moved in standby");

  // The shared temporary register carries the lower byte on 16-bit reads and the upper byte on 16-bit writes.
  temp_latch_a: assert property (@(posedge clk) disable iff (rst)
    (rd_tmp & sel_cnt_h) |=> (temp == $past(counter_low_half)))
    else $error("temp missed the lower counter byte");
  wide_commit_a: assert property (@(posedge clk) disable iff (rst)
    (wr_en & wide_mode & sel_cmp_l)
    |=> (compare_high_half == $past(temp) && compare_low_half == $past(wr_data)))
    else $error("compare bytes not committed together");
endmodule : dmct_timer

/* testbench/dmct_prescale_model.sv */
// Prescaler model that feeds the timer its four one-cycle tick pulses.
// Assumes the system clock and reset of the timer; the watch tick rate is a free choice.
`timescale 1ns/10ps
module dmct_prescale_model (
  input  wire logic               clk,
  input  wire logic               rst,
  output dmct_pkg::dmct_ticks_type ticks
);
  logic [4:0] div_cnt;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt <= 5'h00;
    end else begin
      div_cnt <= div_cnt + 5'h01;
    end
  end

  // Each tick is high for exactly one clock, as the timer expects.
  assign ticks.div32  = (div_cnt == 5'h1f);
  assign ticks.div16  = (div_cnt[3:0] == 4'hf);
  assign ticks.div4   = (div_cnt[1:0] == 2'h3);
  assign ticks.watch4 = (div_cnt[2:0] == 3'h7);
endmodule : dmct_prescale_model

/* testbench/dual_mode_compare_timer_tb_top.sv */
// Self-checking testbench of the dual-mode compare timer.
// Assumes the prescale model as tick source; inputs change at the falling clock edge.
`timescale 1ns/10ps
module dual_mode_compare_timer_tb_top;
  logic                     clk = 1'b0;
  logic                     rst = 1'b1;
  logic                     wr_en = 1'b0;
  logic                     rd_en = 1'b0;
  logic                     event_input_pin = 1'b0;
  logic                     event_rising = 1'b1;
  logic [15:0]              addr = 16'h0000;
  logic [7:0]               wr_data = 8'h00;
  logic [7:0]               rd_data;
  logic [7:0]               v;
  logic                     high_toggle_pin;
  logic                     low_toggle_pin;
  logic                     high_irq_request;
  logic                     low_irq_request;
  logic                     prev_pin = 1'b0;
  dmct_pkg::dmct_ticks_type ticks;
  int                       miscompares = 0;
  int                       check_count = 0;
  int                       lo_irqs = 0;
  int                       hi_flips = 0;
  int                       hi_irqs = 0;

  always #25 clk = ~clk;

  dmct_prescale_model pre_u (.clk(clk), .rst(rst), .ticks(ticks));

  dmct_timer dut_u (.clk(clk), .rst(rst), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
    .wr_data(wr_data), .ticks(ticks), .event_input_pin(event_input_pin),
    .event_rising(event_rising), .rd_data(rd_data), .high_toggle_pin(high_toggle_pin),
    .low_toggle_pin(low_toggle_pin), .high_irq_request(high_irq_request),
    .low_irq_request(low_irq_request));

  always @(negedge clk) begin
    if (low_irq_request === 1'b1) lo_irqs++;
    if (high_irq_request === 1'b1) hi_irqs++;
    if (high_toggle_pin !== prev_pin) hi_flips++;
    prev_pin = high_toggle_pin;
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wr_data = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    d = rd_data;
  endtask : rd

  task automatic do_reset();
    @(negedge clk);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    lo_irqs = 0;
    hi_flips = 0;
    hi_irqs = 0;
  endtask : do_reset

  task automatic test_reset_values();
    rd(16'hffb8, v); chk("cnt_high", 8'h00, v);
    rd(16'hffb9, v); chk("cnt_low", 8'h00, v);
    rd(16'hffba, v); chk("cmp_high", 8'hff, v);
    rd(16'hffbb, v); chk("cmp_low", 8'hff, v);
    rd(16'hffb6, v); chk("mode_ctrl", 8'h00, v);
    rd(16'hffb7, v); chk("flags", 8'h00, v);
    rd(16'hfffa, v); chk("clk_stop", 8'hff, v);
    chk("pins", 8'h00, {6'h00, high_toggle_pin, low_toggle_pin});
    wr(16'hffb6, 8'h88);
    chk("pins_set", 8'h03, {6'h00, high_toggle_pin, low_toggle_pin});
    $display("test reset_values done");
  endtask : test_reset_values

  task automatic test_event_count();
    // Three rising edges on the event pin, counted by the low half in 16-bit mode.
    repeat (3) begin
      @(negedge clk) event_input_pin = 1'b1;
      repeat (4) @(negedge clk);
      event_input_pin = 1'b0;
      repeat (4) @(negedge clk);
    end
    rd(16'hffb8, v); chk("wide_high", 8'h00, v);
    rd(16'hffb9, v); chk("wide_low", 8'h03, v);
    event_rising = 1'b0;
    repeat (2) begin
      @(negedge clk) event_input_pin = 1'b1;
      repeat (4) @(negedge clk);
      event_input_pin = 1'b0;
      repeat (4) @(negedge clk);
    end
    event_rising = 1'b1;
    rd(16'hffb8, v); chk("fall_high", 8'h00, v);
    rd(16'hffb9, v); chk("fall_low", 8'h05, v);
    $display("test event_count done");
  endtask : test_event_count

  task automatic test_split_overflow();
    wr(16'hffb6, 8'h46);
    wr(16'hffb7, 8'h02);
    repeat (1100) @(negedge clk);
    rd(16'hffb7, v); chk("flags_ovf", 8'h0e, v);
    chk("low_irqs", 8'h02, 8'(lo_irqs));
    chk("low_pin", 8'h01, {7'h00, low_toggle_pin});
    wr(16'hffb7, 8'hff);
    rd(16'hffb7, v); chk("flags_set1", 8'h3f, v);
    wr(16'hffb7, 8'h02);
    rd(16'hffb7, v); chk("flags_clr", 8'h02, v);
    $display("test split_overflow done");
  endtask : test_split_overflow

  task automatic test_wide_compare();
    wr(16'hffb6, 8'h06);
    wr(16'hffba, 8'h00);
    wr(16'hffbb, 8'h05);
    wr(16'hffb7, 8'h10);
    repeat (130) @(negedge clk);
    rd(16'hffb7, v); chk("flags_cmf", 8'h50, v);
    rd(16'hffb8, v); chk("wide_high", 8'h00, v);
    rd(16'hffb9, v); chk("wide_low_le5", 8'h01, {7'h00, v <= 8'h05});
    chk("hi_flips", 8'h01, {7'h00, hi_flips >= 4});
    chk("hi_irqs", 8'h01, {7'h00, hi_irqs >= 4});
    chk("lo_pin", 8'h00, {7'h00, low_toggle_pin});
    $display("test wide_compare done");
  endtask : test_wide_compare

  task automatic test_standby();
    wr(16'hfffa, 8'hfb);
    wr(16'hffb6, 8'he6);
    repeat (40) @(negedge clk);
    rd(16'hffb8, v); chk("stop_high", 8'h00, v);
    rd(16'hffb9, v); chk("stop_low", 8'h00, v);
    chk("pin_high", 8'h01, {7'h00, high_toggle_pin});
    wr(16'hfffa, 8'hff);
    repeat (40) @(negedge clk);
    rd(16'hffb8, v); chk("run_high", 8'h01, {7'h00, v >= 8'h08});
    rd(16'hffb9, v); chk("run_low", 8'h01, {7'h00, v >= 8'h08});
    $display("test standby done");
  endtask : test_standby

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  initial begin
    #(10000 * 50);
    miscompares++;
    end_sim();
  end

  initial begin
    do_reset();
    test_reset_values();
    do_reset();
    test_event_count();
    do_reset();
    test_split_overflow();
    do_reset();
    test_wide_compare();
    do_reset();
    test_standby();
    end_sim();
  end
endmodule : dual_mode_compare_timer_tb_top
